//--- src/maa_pkg.sv
/*
 * shared constants, opcode codes, operation kinds and the opcode decoder
 * of the memory atomic unit.
 * assumes one clock domain and a dword-addressed local memory.
 */
package maa_pkg;

    localparam int unsigned MAA_ADDR_W = 6;    // dword address bits
    localparam int unsigned MAA_ROW_W  = 5;    // one row holds a dword pair
    localparam int unsigned MAA_ROWS   = 32;
    localparam logic [63:0] MAA_RSP_RST = 64'h0000_0000_0000_0000;

    // image space (narrow only)
    localparam logic [6:0] OP_IMAGE_EXCHANGE         = 7'h10;
    localparam logic [6:0] OP_IMAGE_BITWISE_EXCLUSIVE = 7'h1a;
    // buffer space
    localparam logic [6:0] OP_BUFFER_WRAP_INCREMENT  = 7'h4b;
    localparam logic [6:0] OP_BUFFER_WRAP_DECREMENT  = 7'h4c;
    localparam logic [6:0] OP_BUFFER_EXCHANGE_WIDE   = 7'h60;
    localparam logic [6:0] OP_BUFFER_COMPARE_EXCHANGE_WIDE = 7'h61;
    localparam logic [6:0] OP_BUFFER_SUM_WIDE        = 7'h62;
    localparam logic [6:0] OP_BUFFER_DIFFERENCE_WIDE = 7'h63;
    localparam logic [6:0] OP_BUFFER_CONJUNCTION_WIDE = 7'h68;
    localparam logic [6:0] OP_BUFFER_DISJUNCTION_WIDE = 7'h69;
    localparam logic [6:0] OP_BUFFER_EXCLUSIVE_WIDE  = 7'h6a;
    localparam logic [6:0] OP_BUFFER_WRAP_INCREMENT_WIDE = 7'h6b;
    localparam logic [6:0] OP_BUFFER_WRAP_DECREMENT_WIDE = 7'h6c;

    // image codes 16..26 map in this order onto the first eleven kinds
    typedef enum logic [3:0] {
        K_SWAP, K_CMPSWAP, K_ADD, K_SUB, K_SMIN, K_UMIN, K_SMAX, K_UMAX,
        K_AND, K_OR, K_XOR, K_INC, K_DEC, K_BAD
    } maa_kind_t;

    typedef struct packed {
        maa_kind_t kind;
        logic      wide;
    } maa_dec_t;

    function automatic maa_dec_t maa_decode(input logic image,
                                            input logic [6:0] op);
        maa_dec_t d;
        logic [6:0] rel;
        d.kind = K_BAD;
        d.wide = 1'b0;
        rel    = op - OP_IMAGE_EXCHANGE;
        if (image) begin
            if (op >= OP_IMAGE_EXCHANGE && op <= OP_IMAGE_BITWISE_EXCLUSIVE)
                d.kind = maa_kind_t'(rel[3:0]);
        end else begin
            d.wide = 1'b1;
            case (op)
                OP_BUFFER_WRAP_INCREMENT: begin
                    d.kind = K_INC;
                    d.wide = 1'b0;
                end
                OP_BUFFER_WRAP_DECREMENT: begin
                    d.kind = K_DEC;
                    d.wide = 1'b0;
                end
                OP_BUFFER_EXCHANGE_WIDE:         d.kind = K_SWAP;
                OP_BUFFER_COMPARE_EXCHANGE_WIDE: d.kind = K_CMPSWAP;
                OP_BUFFER_SUM_WIDE:              d.kind = K_ADD;
                OP_BUFFER_DIFFERENCE_WIDE:       d.kind = K_SUB;
                OP_BUFFER_CONJUNCTION_WIDE:      d.kind = K_AND;
                OP_BUFFER_DISJUNCTION_WIDE:      d.kind = K_OR;
                OP_BUFFER_EXCLUSIVE_WIDE:        d.kind = K_XOR;
                OP_BUFFER_WRAP_INCREMENT_WIDE:   d.kind = K_INC;
                OP_BUFFER_WRAP_DECREMENT_WIDE:   d.kind = K_DEC;
                default:                         d.kind = K_BAD;
            endcase
        end
        return d;
    endfunction

endpackage

//--- src/maa_mem_if.sv
/*
 * carrier between the atomic sequencer and its local memory.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface maa_mem_if
    import maa_pkg::*;
();
    logic                 re;
    logic [MAA_ROW_W-1:0] raddr;
    logic [MAA_ROW_W-1:0] waddr;
    logic [1:0]           we;      // per dword of the row
    logic [63:0]          wdata;
    logic [63:0]          rdata;

    modport ctl (output re, raddr, waddr, we, wdata, input rdata);
    modport mem (input re, raddr, waddr, we, wdata, output rdata);
endinterface
`default_nettype wire

//--- src/maa_mem.sv
/*
 * local memory of dword pairs, registered read data, dword write enables.
 * assumes the sequencer never reads and writes one row in one cycle.
 */
`timescale 1ns/10ps
`default_nettype none
module maa_mem
    import maa_pkg::*;
(
    input  wire logic  clk_i,
    maa_mem_if.mem     port
);
    logic [63:0] store [MAA_ROWS];
    logic [63:0] rdata_r;

    // contents hold no reset value; software seeds them with swaps
    always_ff @(posedge clk_i) begin
        if (port.re)
            rdata_r <= store[port.raddr];
        if (port.we[0])
            store[port.waddr][31:0] <= port.wdata[31:0];
        if (port.we[1])
            store[port.waddr][63:32] <= port.wdata[63:32];
    end

    assign port.rdata = rdata_r;
endmodule // maa_mem
`default_nettype wire

//--- src/maa_top.sv
/*
 * memory atomic unit: takes one atomic request, reads the old word or
 * dword pair, combines it, writes it back and returns the old value.
 * assumes the requester holds a request until it is taken.
 */
`timescale 1ns/10ps
`default_nettype none
module maa_top
    import maa_pkg::*;
(
    input  wire logic                  MCLK_I,
    input  wire logic                  RST_I,
    input  wire logic                  REQ_VALID_I,
    output logic                       REQ_READY_O,
    input  wire logic                  REQ_IMAGE_I,
    input  wire logic [6:0]            REQ_OP_I,
    input  wire logic [MAA_ADDR_W-1:0] REQ_ADDR_I,
    input  wire logic [127:0]          REQ_DATA_I,
    output logic                       RSP_VALID_O,
    output logic                       RSP_ERR_O,
    output logic [63:0]                RSP_DATA_O
);
    typedef enum logic {ST_IDLE, ST_MODIFY} maa_state_t;

    maa_mem_if mif ();

    maa_state_t            st_r,     st_nxt;
    maa_kind_t             kind_r,   kind_nxt;
    logic                  wide_r,   wide_nxt;
    logic [MAA_ADDR_W-1:0] addr_r,   addr_nxt;
    logic [63:0]           data_r,   data_nxt;
    logic [63:0]           cmp_r,    cmp_nxt;
    logic                  rsp_v_r,  rsp_v_nxt;
    logic                  rsp_e_r,  rsp_e_nxt;
    logic [63:0]           rsp_d_r,  rsp_d_nxt;

    maa_dec_t    dec;
    logic        take;
    logic        bad;
    logic        sgn;
    logic        less;
    logic [63:0] old_v;
    logic [63:0] old_x;
    logic [63:0] dat_x;
    logic [63:0] cmp_x;
    logic [63:0] new_x;

    maa_mem u_mem (
        .clk_i (MCLK_I),
        .port  (mif.mem)
    );

    // only idle takes work, so no access slips between read and write
    assign REQ_READY_O = (st_r == ST_IDLE);
    assign take        = REQ_VALID_I && REQ_READY_O;
    assign dec         = maa_decode(REQ_IMAGE_I, REQ_OP_I);

    // old value: narrow picks the dword, wide the whole pair
    always_comb begin
        old_v = wide_r ? mif.rdata
                       : {32'h0000_0000, addr_r[0] ? mif.rdata[63:32]
                                                   : mif.rdata[31:0]};
    end

    // operand widening: signed kinds sign-extend narrow values
    always_comb begin
        sgn   = (kind_r == K_SMIN) || (kind_r == K_SMAX);
        old_x = old_v;
        dat_x = data_r;
        cmp_x = cmp_r;
        if (!wide_r) begin
            old_x = {sgn ? {32{old_v[31]}} : 32'h0000_0000, old_v[31:0]};
            dat_x = {sgn ? {32{data_r[31]}} : 32'h0000_0000, data_r[31:0]};
            cmp_x = {32'h0000_0000, cmp_r[31:0]};
        end
        less = sgn ? ($signed(dat_x) < $signed(old_x)) : (dat_x < old_x);
    end

    // combine old value with request data
    always_comb begin
        case (kind_r)
            K_SWAP:    new_x = dat_x;
            K_CMPSWAP: new_x = (old_x == cmp_x) ? dat_x : old_x;
            K_ADD:     new_x = old_x + dat_x;
            K_SUB:     new_x = old_x - dat_x;
            K_SMIN,
            K_UMIN:    new_x = less ? dat_x : old_x;
            K_SMAX,
            K_UMAX:    new_x = (!less && dat_x != old_x)
                               ? dat_x : old_x;
            K_AND:     new_x = old_x & dat_x;
            K_OR:      new_x = old_x | dat_x;
            K_XOR:     new_x = old_x ^ dat_x;
            K_INC:     new_x = (old_x >= dat_x) ? 64'h0000_0000_0000_0000
                                                : old_x + 64'h1;
            K_DEC:     new_x = (old_x == 64'h0 || old_x > dat_x)
                               ? dat_x : old_x - 64'h1;
            default:   new_x = old_x;
        endcase
    end

    // misaligned wide work and unknown codes answer with error, no write
    assign bad = (kind_r == K_BAD) || (wide_r && addr_r[0]);

    // memory port: read on take, write in the modify cycle
    always_comb begin
        mif.re    = take;
        mif.raddr = REQ_ADDR_I[MAA_ADDR_W-1:1];
        mif.waddr = addr_r[MAA_ADDR_W-1:1];
        mif.wdata = wide_r ? new_x : {new_x[31:0], new_x[31:0]};
        mif.we    = 2'b00;
        if (st_r == ST_MODIFY && !bad) begin
            if (wide_r)
                mif.we = 2'b11;
            else
                mif.we = addr_r[0] ? 2'b10 : 2'b01;
        end
    end

    // sequencer next state
    always_comb begin
        st_nxt    = st_r;
        kind_nxt  = kind_r;
        wide_nxt  = wide_r;
        addr_nxt  = addr_r;
        data_nxt  = data_r;
        cmp_nxt   = cmp_r;
        rsp_v_nxt = 1'b0;
        rsp_e_nxt = 1'b0;
        rsp_d_nxt = rsp_d_r;
        case (st_r)
            ST_IDLE: begin
                if (take) begin
                    st_nxt   = ST_MODIFY;
                    kind_nxt = dec.kind;
                    wide_nxt = dec.wide;
                    addr_nxt = REQ_ADDR_I;
                    // wide: data in dwords 0..1, comparand in 2..3
                    data_nxt = dec.wide ? REQ_DATA_I[63:0]
                                        : {32'h0000_0000, REQ_DATA_I[31:0]};
                    cmp_nxt  = dec.wide ? REQ_DATA_I[127:64]
                                        : {32'h0000_0000, REQ_DATA_I[63:32]};
                end
            end
            ST_MODIFY: begin
                st_nxt    = ST_IDLE;
                rsp_v_nxt = 1'b1;
                rsp_e_nxt = bad;
                rsp_d_nxt = bad ? MAA_RSP_RST : old_v;
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            st_r    <= ST_IDLE;
            kind_r  <= K_BAD;
            wide_r  <= 1'b0;
            addr_r  <= '0;
            data_r  <= MAA_RSP_RST;
            cmp_r   <= MAA_RSP_RST;
            rsp_v_r <= 1'b0;
            rsp_e_r <= 1'b0;
            rsp_d_r <= MAA_RSP_RST;
        end else begin
            st_r    <= st_nxt;
            kind_r  <= kind_nxt;
            wide_r  <= wide_nxt;
            addr_r  <= addr_nxt;
            data_r  <= data_nxt;
            cmp_r   <= cmp_nxt;
            rsp_v_r <= rsp_v_nxt;
            rsp_e_r <= rsp_e_nxt;
            rsp_d_r <= rsp_d_nxt;
        end
    end

    assign RSP_VALID_O = rsp_v_r;
    assign RSP_ERR_O   = rsp_e_r;
    assign RSP_DATA_O  = rsp_d_r;

    // checks on the modify cycle and the response timing
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);

    logic mod_ok;
    assign mod_ok = (st_r == ST_MODIFY) && !bad;

    property p_swap;
        mod_ok && kind_r == K_SWAP |-> mif.wdata[31:0] == data_r[31:0];
    endproperty
    a_swap: assert property (p_swap) else $error("swap data wrong");

    // a miss must write back the old value, narrow dword or whole pair
    property p_cmp_keep;
        mod_ok && kind_r == K_CMPSWAP && old_x != cmp_x
            |-> (wide_r ? mif.wdata : {32'h0000_0000, mif.wdata[31:0]})
                == old_v;
    endproperty
    a_cmp_keep: assert property (p_cmp_keep)
        else $error("cmpswap changed");

    property p_add;
        mod_ok && kind_r == K_ADD && wide_r
            |-> mif.wdata == old_v + data_r;
    endproperty
    a_add: assert property (p_add) else $error("add result wrong");

    property p_umin;
        mod_ok && kind_r == K_UMIN && !wide_r
            |-> mif.wdata[31:0] <= data_r[31:0]
                && mif.wdata[31:0] <= old_v[31:0];
    endproperty
    a_umin: assert property (p_umin) else $error("umin not minimal");

    property p_smax;
        mod_ok && kind_r == K_SMAX && !wide_r
            |-> $signed(mif.wdata[31:0]) >= $signed(data_r[31:0])
                && $signed(mif.wdata[31:0]) >= $signed(old_v[31:0]);
    endproperty
    a_smax: assert property (p_smax) else $error("smax not maximal");

    property p_xor;
        mod_ok && kind_r == K_XOR && wide_r
            |-> (mif.wdata ^ old_v) == data_r;
    endproperty
    a_xor: assert property (p_xor) else $error("xor result wrong");

    property p_inc_wrap;
        mod_ok && kind_r == K_INC && old_x >= dat_x
            |-> mif.wdata == 64'h0000_0000_0000_0000;
    endproperty
    a_inc_wrap: assert property (p_inc_wrap)
        else $error("inc no wrap");

    property p_dec_zero;
        mod_ok && kind_r == K_DEC && wide_r && old_v == 64'h0
            |-> mif.wdata == data_r;
    endproperty
    a_dec_zero: assert property (p_dec_zero)
        else $error("dec wrap wrong");

    property p_dec_known;
        take && !REQ_IMAGE_I && REQ_OP_I == OP_BUFFER_WRAP_DECREMENT
            ##2 RSP_VALID_O |-> !RSP_ERR_O;
    endproperty
    a_dec_known: assert property (p_dec_known)
        else $error("dec refused");

    property p_atomic;
        take |=> !REQ_READY_O ##1 (RSP_VALID_O && REQ_READY_O);
    endproperty
    a_atomic: assert property (p_atomic) else $error("rmw not atomic");

    property p_wide_pair;
        mod_ok && wide_r |-> mif.we == 2'b11 && !addr_r[0];
    endproperty
    a_wide_pair: assert property (p_wide_pair)
        else $error("pair split");

    c_wide:  cover property (take && dec.wide ##2 RSP_VALID_O);
    c_cmp:   cover property (mod_ok && kind_r == K_CMPSWAP && old_x == cmp_x);
    c_b2b:   cover property (take ##2 take);
    c_err:   cover property (RSP_VALID_O && RSP_ERR_O);
endmodule // maa_top
`default_nettype wire

//--- dv/maa_core_model.sv
/*
 * requester model standing in for the shader core of the atomic unit.
 * assumes one clock shared with the unit; drives at the falling edge.
 */
`timescale 1ns/10ps
`default_nettype none
module maa_core_model
    import maa_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  ready_i,
    input  wire logic                  rsp_valid_i,
    input  wire logic                  rsp_err_i,
    input  wire logic [63:0]           rsp_data_i,
    output logic                       valid_o,
    output logic                       image_o,
    output logic [6:0]                 op_o,
    output logic [MAA_ADDR_W-1:0]      addr_o,
    output logic [127:0]               data_o
);
    // idle at time zero
    initial begin
        valid_o = 1'b0;
        image_o = 1'b0;
        op_o    = 7'h00;
        addr_o  = '0;
        data_o  = '0;
    end

    // one request: hold until taken, then collect the answer
    task automatic issue(input logic img, input logic [6:0] op,
            input logic [MAA_ADDR_W-1:0] a, input logic [127:0] d,
            input int gap, output logic err, output logic [63:0] rd,
            output bit got);
        int n;
        repeat (gap) @(negedge clk_i);
        valid_o = 1'b1;
        image_o = img;
        op_o    = op;
        addr_o  = a;
        data_o  = d;
        n = 0;
        // ready comes from a state register, so stable at this edge
        while (ready_i !== 1'b1 && n < 8) begin
            @(negedge clk_i);
            n++;
        end
        @(negedge clk_i);
        valid_o = 1'b0;
        // released data and address lines must not keep showing the old request
        data_o  = ~data_o;
        addr_o  = ~addr_o;
        got = 1'b0;
        n = 0;
        while (!got && n < 4) begin
            if (rsp_valid_i === 1'b1) got = 1'b1;
            else begin
                @(negedge clk_i);
                n++;
            end
        end
        err = rsp_err_i;
        rd  = rsp_data_i;
    endtask
endmodule // maa_core_model
`default_nettype wire

//--- dv/memory_atomic_alu_bench.sv
/*
 * self-checking bench of the memory atomic unit with a reference memory.
 * assumes the unit's memory is unknown until every dword is seeded.
 */
`timescale 1ns/10ps
`default_nettype none
module memory_atomic_alu_bench;
    import maa_pkg::*;
    logic mclk, rst;
    wire logic req_valid, req_ready, req_image, rsp_valid, rsp_err;
    wire logic [6:0] req_op;
    wire logic [5:0] req_addr;
    wire logic [127:0] req_data;
    wire logic [63:0] rsp_data;
    int failures, n_compared, cycles, seed, i, r;
    logic [31:0] mem_ref [64];
    logic [6:0] bufops [11] = '{7'h4b, 7'h4c, 7'h60, 7'h61, 7'h62,
        7'h63, 7'h68, 7'h69, 7'h6a, 7'h6b, 7'h6c};
    logic [31:0] lims [5] = '{32'h0000_0005, 32'h0000_0005,
        32'h0000_0007, 32'h0000_0007, 32'h0000_0003};
    logic [6:0] op;
    logic [5:0] a;
    logic [127:0] d;
    logic img, w;

    maa_top maa_top_inst (.MCLK_I(mclk), .RST_I(rst),
        .REQ_VALID_I(req_valid), .REQ_READY_O(req_ready),
        .REQ_IMAGE_I(req_image), .REQ_OP_I(req_op),
        .REQ_ADDR_I(req_addr), .REQ_DATA_I(req_data),
        .RSP_VALID_O(rsp_valid), .RSP_ERR_O(rsp_err),
        .RSP_DATA_O(rsp_data));
    maa_core_model maa_core_model_inst (.clk_i(mclk), .ready_i(req_ready),
        .rsp_valid_i(rsp_valid), .rsp_err_i(rsp_err),
        .rsp_data_i(rsp_data), .valid_o(req_valid), .image_o(req_image),
        .op_o(req_op), .addr_o(req_addr), .data_o(req_data));

    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // hang guard, far above the 1550 or so cycles needed
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 10000) begin
            failures++;
            test_done();
        end
    end

    task automatic test_done();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // kind index 0..12 in image order, -1 when not decoded
    function automatic int kind_of(input logic im, input logic [6:0] o);
        if (im) return (o >= 7'h10 && o <= 7'h1a) ? int'(o) - 16 : -1;
        case (o)
            7'h4b, 7'h6b: return 11;
            7'h4c, 7'h6c: return 12;
            7'h60, 7'h61, 7'h62, 7'h63, 7'h68, 7'h69, 7'h6a:
                return int'(o) - 96;
            default: return -1;
        endcase
    endfunction

    // narrow values ride in the top half so one compare serves both
    function automatic logic [63:0] new_val(input int k, input logic wd,
            input logic [63:0] o0, input logic [127:0] dd);
        logic [63:0] o, x, c, s, q;
        s = wd ? 64'h0000_0000_0000_0001 : 64'h0000_0001_0000_0000;
        o = wd ? o0 : {o0[31:0], 32'h0000_0000};
        x = wd ? dd[63:0] : {dd[31:0], 32'h0000_0000};
        c = wd ? dd[127:64] : {dd[63:32], 32'h0000_0000};
        case (k)
            0: q = x;
            1: q = (o == c) ? x : o;
            2: q = o + x;
            3: q = o - x;
            4: q = ($signed(x) < $signed(o)) ? x : o;
            5: q = (x < o) ? x : o;
            6: q = ($signed(x) > $signed(o)) ? x : o;
            7: q = (x > o) ? x : o;
            8: q = o & x;
            9: q = o | x;
            10: q = o ^ x;
            11: q = (o >= x) ? 64'h0 : o + s;
            default: q = (o == 64'h0 || o > x) ? x : o - s;
        endcase
        return wd ? q : {32'h0000_0000, q[63:32]};
    endfunction

    // one atomic through the partner, checked against the reference
    task automatic run(input logic im, input logic [6:0] o,
            input logic [5:0] ad, input logic [127:0] dd, input bit chk);
        int k;
        logic wd, bad, err;
        logic [63:0] old, nv, rd;
        bit got;
        k = kind_of(im, o);
        wd = !im && o != 7'h4b && o != 7'h4c;
        bad = (k < 0) || (wd && ad[0]);
        old = wd ? {mem_ref[ad | 6'h01], mem_ref[ad]} : {32'h0, mem_ref[ad]};
        maa_core_model_inst.issue(im, o, ad, dd, $unsigned($random(seed)) % 3,
            err, rd, got);
        check({63'h0, got}, 64'h1);
        if (chk) begin
            check({63'h0, err}, {63'h0, bad});
            check(rd, bad ? 64'h0 : old);
        end
        if (!bad) begin
            nv = new_val(k, wd, old, dd);
            mem_ref[ad] = nv[31:0];
            if (wd) mem_ref[ad | 6'h01] = nv[63:32];
        end
    endtask

    task automatic do_reset();
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        check({61'h0, req_ready, rsp_valid, rsp_err}, 64'h4);
        check(rsp_data, 64'h0);
    endtask

    function automatic logic [127:0] rnd();
        return {$random(seed), $random(seed), $random(seed), $random(seed)};
    endfunction

    // main sequence: seed, corner cases, every opcode, then random
    initial begin
        seed = 18241;
        failures = 0;
        n_compared = 0;
        cycles = 0;
        do_reset();
        for (i = 0; i < 64; i++) run(1, 7'h10, 6'(i), rnd(), 0);
        run(1, 7'h10, 6'd3, {96'h0, 32'h1234_5678}, 1);
        run(1, 7'h11, 6'd3, {64'h0, 32'h1234_5678, 32'h0000_00aa}, 1);
        run(1, 7'h11, 6'd3, {64'h0, 32'h1234_5678, 32'h0000_00bb}, 1);
        run(1, 7'h10, 6'd4, {96'h0, 32'hffff_ffff}, 1);
        run(1, 7'h12, 6'd4, {96'h0, 32'h0000_0001}, 1);
        run(1, 7'h13, 6'd4, {96'h0, 32'h0000_0001}, 1);
        for (i = 0; i < 4; i++) begin
            run(1, 7'h10, 6'd5, {96'h0, 32'h0000_0001}, 1);
            run(1, 7'h14 + 7'(i), 6'd5, {96'h0, 32'h8000_0000}, 1);
        end
        run(1, 7'h10, 6'd6, {96'h0, 32'h0000_0005}, 1);
        for (i = 0; i < 5; i++)
            run(0, i < 2 ? 7'h4b : 7'h4c, 6'd6, {96'h0, lims[i]}, 1);
        run(0, 7'h60, 6'd8, {64'h0, 64'h0000_0000_ffff_ffff}, 1);
        for (i = 0; i < 2; i++)
            run(0, 7'h6b, 6'd8, {64'h0, 64'h0000_0001_0000_0000}, 1);
        run(0, 7'h6c, 6'd8, {64'h0, 64'h1234_5678_9abc_def0}, 1);
        run(0, 7'h61, 6'd8, {64'h1234_5678_9abc_def0, 64'h0000_0001}, 1);
        run(1, 7'h1b, 6'd9, rnd(), 1);
        run(0, 7'h64, 6'd8, rnd(), 1);
        run(0, 7'h60, 6'd9, rnd(), 1);
        for (i = 0; i < 22; i++)
            run(i < 11, i < 11 ? 7'h10 + 7'(i) : bufops[i - 11],
                6'($random(seed)) & 6'h3e, rnd(), 1);
        do_reset();
        for (i = 0; i < 400; i++) begin
            r = $unsigned($random(seed)) % 24;
            img = r < 11 || (r >= 22 && seed[0]);
            op = r < 11 ? 7'h10 + 7'(r) : r < 22 ? bufops[r - 11]
                : 7'($random(seed));
            w = !img && op != 7'h4b && op != 7'h4c;
            a = 6'($random(seed));
            if (w && seed[2:1] != 2'b00) a[0] = 1'b0;
            d = rnd();
            // operand equal to the old value hits the wrap and match cases
            if (seed[4:3] == 2'b00)
                d = w ? {2{mem_ref[a | 6'h01], mem_ref[a]}}
                      : {64'h0, {2{mem_ref[a]}}};
            run(img, op, a, d, 1);
        end
        test_done();
    end
endmodule // memory_atomic_alu_bench
`default_nettype wire
